//--- logic/atm_pkg.sv
// Purpose: shared constants and types for the card-side transport mapper
// Assumes: one 50 MHz clock, byte-wide streams
// Notes:   status words are {sw1, sw2}; byte counts run 0..256
package atm_pkg;

    // widths and buffer shape
    localparam int          BYTE_W      = 8;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          CNT_W       = 9;

    // largest response of one header (an expected length of zero asks for this)
    localparam logic [8:0]  FULL_LEN    = 9'h100;

    // status words and procedure bytes
    localparam logic [15:0] SW_OK       = 16'h9000;
    localparam logic [7:0]  PB_FETCH    = 8'h61;
    localparam logic [7:0]  PB_RESEND   = 8'h6C;
    localparam logic [7:0]  SW1_WARN_A  = 8'h62;
    localparam logic [7:0]  SW1_WARN_B  = 8'h63;
    localparam logic [3:0]  SW1_APP_HI  = 4'h9;
    // answer when a fetch finds nothing pending, or a case 1/3 result misuses a fetch code
    localparam logic [15:0] SW_NO_DATA  = 16'h6F00;
    // answer for a clean case 4 result that produced no data
    localparam logic [15:0] SW_C4_EMPTY = 16'h6200;

    // command case as presented by the header decoder
    typedef enum logic [1:0] {CASE1, CASE2, CASE3, CASE4} atm_case_t;

    // main sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_DATA, ST_SW1, ST_SW2} atm_st_t;

    // outcome of one decision: bytes to move, pending remainder and trailer
    typedef struct packed {
        logic [8:0]  cnt;
        logic        drop;
        logic [8:0]  pend;
        logic        resend;
        logic [15:0] sw;
    } atm_plan_t;

endpackage

//--- logic/atm_fifo.sv
// Purpose: response data buffer between the application and the link
// Assumes: depth is a power of two
// Notes:   honest full and empty; input ready drops when full
`timescale 1ns/1ps
module atm_fifo
#(
    parameter int W = 8,
    parameter int D = 32
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         fill;
    } atm_fifo_t;

    atm_fifo_t fifo_ff;
    atm_fifo_t nxt_fifo;
    logic      push;
    logic      pop;

    // handshakes straight from the fill level
    assign in_ready  = (fifo_ff.fill != D[AW:0]);
    assign out_valid = (fifo_ff.fill != '0);
    assign out_data  = fifo_ff.mem[fifo_ff.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and storage update; push and pop may share a cycle
    always_comb
    begin
        nxt_fifo = fifo_ff;
        if (push)
        begin
            nxt_fifo.mem[fifo_ff.wp] = in_data;
            nxt_fifo.wp              = fifo_ff.wp + 1'b1;
        end
        if (pop)
        begin
            nxt_fifo.rp = fifo_ff.rp + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_fifo.fill = fifo_ff.fill + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_fifo.fill = fifo_ff.fill - 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            fifo_ff <= '0;
        end
        else
        begin
            fifo_ff <= nxt_fifo;
        end
    end

endmodule // atm_fifo

//--- logic/atm_transport_mapper.sv
// Purpose: card-side mapping of responses onto T=0 procedure bytes or T=1 INF bytes
// Assumes: header decoded upstream; application reports status and byte count
// Notes:   response bytes stream through a 32-byte buffer; trailer follows data
`timescale 1ns/1ps
module atm_transport_mapper
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        proto_t1,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [1:0]  cmd_case,
    input  wire logic        cmd_fetch,
    input  wire logic [7:0]  cmd_le,
    input  wire logic        app_done,
    input  wire logic [15:0] app_sw,
    input  wire logic [8:0]  app_avail,
    input  wire logic [7:0]  app_data,
    input  wire logic        app_data_valid,
    output logic             app_data_ready,
    output logic             out_valid,
    output logic [7:0]       out_byte,
    output logic             out_status,
    output logic             out_last,
    input  wire logic        out_ready,
    output logic             busy
);

    typedef struct packed {
        atm_pkg::atm_st_t st;
        logic [8:0]       cnt;
        logic             drop;
        logic             purge;
        logic [8:0]       pend;
        logic             resend;
        logic [15:0]      sw;
        logic             t1;
        logic [1:0]       cs;
        logic [7:0]       le;
        logic             ov;
        logic [7:0]       ob;
        logic             ost;
        logic             olast;
    } atm_map_t;

    atm_map_t         map_ff;
    atm_map_t         nxt_map;
    atm_pkg::atm_plan_t plan;
    logic             take;
    logic             slot;
    logic             fifo_pop;
    logic             fifo_ov;
    logic [7:0]       fifo_byte;

    // decide what goes back: data count, remainder kept, trailer bytes
    function automatic atm_pkg::atm_plan_t make_plan(
        input logic        t1,
        input logic [1:0]  cs,
        input logic [7:0]  le,
        input logic [8:0]  avail,
        input logic [15:0] sw
    );
        atm_pkg::atm_plan_t p;
        logic [8:0]         want;
        logic [8:0]         rest;
        logic               ok;
        p    = '0;
        want = (le == 8'h00) ? atm_pkg::FULL_LEN : {1'b0, le};
        rest = avail - want;
        ok   = (sw == atm_pkg::SW_OK) || (sw[15:8] == atm_pkg::SW1_WARN_A)
            || (sw[15:8] == atm_pkg::SW1_WARN_B) || (sw[15:12] == atm_pkg::SW1_APP_HI);
        // default: drain whatever was produced and send the status alone
        p.sw   = sw;
        p.cnt  = avail;
        p.drop = 1'b1;
        if (t1)
        begin
            p.drop = !ok;
        end
        else if ((cs == 2'(atm_pkg::CASE1)) || (cs == 2'(atm_pkg::CASE3)))
        begin
            if ((sw[15:8] == atm_pkg::PB_FETCH) || (sw[15:8] == atm_pkg::PB_RESEND))
            begin
                p.sw = atm_pkg::SW_NO_DATA;
            end
        end
        else if (cs == 2'(atm_pkg::CASE4))
        begin
            if (sw == atm_pkg::SW_OK)
            begin
                // keep the data for the fetch; never a plain success here
                p.cnt  = '0;
                p.pend = avail;
                p.sw   = (avail == '0) ? atm_pkg::SW_C4_EMPTY
                                       : {atm_pkg::PB_FETCH, avail[7:0]};
            end
            else if (ok)
            begin
                // warning or other accepted status (62xx, 63xx, 9xxx): data stays pending; a zero-length fetch gets 6Cxx, then a fetch of that length
                p.cnt  = '0;
                p.pend = avail;
            end
        end
        else if (ok && (avail != '0))
        begin
            if (((le == 8'h00) && (avail < atm_pkg::FULL_LEN)) || (want > avail))
            begin
                p.cnt    = '0;
                p.pend   = avail;
                p.resend = 1'b1;
                p.sw     = {atm_pkg::PB_RESEND, avail[7:0]};
            end
            else if (want == avail)
            begin
                p.drop = 1'b0;
            end
            else
            begin
                p.drop = 1'b0;
                p.cnt  = want;
                p.pend = rest;
                p.sw   = {atm_pkg::PB_FETCH, rest[7:0]};
            end
        end
        return p;
    endfunction

    atm_fifo #(
        .W (atm_pkg::BYTE_W),
        .D (atm_pkg::FIFO_DEPTH)
    ) atm_fifo_inst (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_data   (app_data),
        .in_valid  (app_data_valid),
        .in_ready  (app_data_ready),
        .out_data  (fifo_byte),
        .out_valid (fifo_ov),
        .out_ready (fifo_pop)
    );

    // output stage can take a new byte when empty or being drained
    assign slot = !map_ff.ov || out_ready;

    // plan for the current event; a served fetch or resend skips the application
    always_comb
    begin
        take = 1'b0;
        plan = make_plan(map_ff.t1, map_ff.cs, map_ff.le, app_avail, app_sw);
        if ((map_ff.st == atm_pkg::ST_IDLE) && cmd_valid && !proto_t1
            && (cmd_fetch || (map_ff.resend && (cmd_case == 2'(atm_pkg::CASE2)))))
        begin
            take = 1'b1;
            plan = make_plan(1'b0, 2'(atm_pkg::CASE2), cmd_le, map_ff.pend,
                             atm_pkg::SW_OK);
            if (map_ff.pend == '0)
            begin
                plan = '0;
                plan.sw = atm_pkg::SW_NO_DATA;
            end
        end
        else if ((map_ff.st == atm_pkg::ST_WAIT) && app_done)
        begin
            take = 1'b1;
        end
    end

    // sequencer: header, wait, data bytes, two trailer bytes
    always_comb
    begin
        nxt_map  = map_ff;
        fifo_pop = 1'b0;
        if (map_ff.ov && out_ready)
        begin
            nxt_map.ov = 1'b0;
        end
        case (map_ff.st)
            atm_pkg::ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    nxt_map.t1 = proto_t1;
                    nxt_map.cs = cmd_case;
                    nxt_map.le = cmd_le;
                    if (!take)
                    begin
                        // a new command abandons any leftover response bytes
                        nxt_map.resend = 1'b0;
                        nxt_map.pend   = '0;
                        nxt_map.cnt    = map_ff.pend;
                        nxt_map.drop   = 1'b1;
                        nxt_map.purge  = 1'b1;
                        nxt_map.st     = (map_ff.pend != '0) ? atm_pkg::ST_DATA
                                                             : atm_pkg::ST_WAIT;
                    end
                end
            end
            atm_pkg::ST_DATA:
            begin
                if (map_ff.cnt == '0)
                begin
                    nxt_map.st = map_ff.purge ? atm_pkg::ST_WAIT : atm_pkg::ST_SW1;
                end
                else if (fifo_ov && (map_ff.drop || slot))
                begin
                    fifo_pop    = 1'b1;
                    nxt_map.cnt = map_ff.cnt - 1'b1;
                    if (!map_ff.drop)
                    begin
                        nxt_map.ov    = 1'b1;
                        nxt_map.ob    = fifo_byte;
                        nxt_map.ost   = 1'b0;
                        nxt_map.olast = 1'b0;
                    end
                end
            end
            atm_pkg::ST_SW1:
            begin
                if (slot)
                begin
                    nxt_map.ov    = 1'b1;
                    nxt_map.ob    = map_ff.sw[15:8];
                    nxt_map.ost   = 1'b1;
                    nxt_map.olast = 1'b0;
                    nxt_map.st    = atm_pkg::ST_SW2;
                end
            end
            atm_pkg::ST_SW2:
            begin
                if (slot)
                begin
                    nxt_map.ov    = 1'b1;
                    nxt_map.ob    = map_ff.sw[7:0];
                    nxt_map.ost   = 1'b1;
                    nxt_map.olast = 1'b1;
                    nxt_map.st    = atm_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_map.st = map_ff.st;
            end
        endcase
        // accepted plan: move data first, trailer follows
        if (take)
        begin
            nxt_map.cnt    = plan.cnt;
            nxt_map.drop   = plan.drop;
            nxt_map.pend   = plan.pend;
            nxt_map.resend = plan.resend;
            nxt_map.sw     = plan.sw;
            nxt_map.purge  = 1'b0;
            nxt_map.st     = (plan.cnt != '0) ? atm_pkg::ST_DATA : atm_pkg::ST_SW1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            map_ff <= '0;
        end
        else
        begin
            map_ff <= nxt_map;
        end
    end

    // outputs straight from the state register
    assign cmd_ready  = (map_ff.st == atm_pkg::ST_IDLE);
    assign busy       = (map_ff.st != atm_pkg::ST_IDLE);
    assign out_valid  = map_ff.ov;
    assign out_byte   = map_ff.ob;
    assign out_status = map_ff.ost;
    assign out_last   = map_ff.olast;

endmodule // atm_transport_mapper

//--- testbench/atm_transport_mapper_checker.sv
// Purpose: port-level assertions for the card-side transport mapper
// Assumes: one clock, synchronous active-low reset
// Notes:   header kind is latched when taken so trailer checks know what they answer
`timescale 1ns/1ps
module atm_transport_mapper_checker
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       proto_t1,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_ready,
    input  wire logic [1:0] cmd_case,
    input  wire logic       cmd_fetch,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_byte,
    input  wire logic       out_status,
    input  wire logic       out_last,
    input  wire logic       out_ready,
    input  wire logic       busy
);
    logic       t1_ff;
    logic       fetch_ff;
    logic       data_ff;
    logic [1:0] case_ff;
    logic [7:0] sw1_ff;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // remember header kind, whether data went out, and the first trailer byte
    always_ff @(posedge clk_sys)
    begin
        if (cmd_valid && cmd_ready)
        begin
            t1_ff    <= proto_t1;
            case_ff  <= cmd_case;
            fetch_ff <= cmd_fetch;
            data_ff  <= 1'b0;
        end
        if (out_valid && out_ready && !out_status)
            data_ff <= 1'b1;
        if (out_valid && out_ready && out_status && !out_last)
            sw1_ff <= out_byte;
    end

    AST_OUT_HOLD: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_byte) && $stable(out_last))
        else $error("output byte changed while stalled");
    AST_LAST_IS_SW: assert property (out_valid && out_last |-> out_status)
        else $error("final byte not a status byte");
    AST_SW2_FOLLOWS: assert property (
        out_valid && out_ready && out_status && !out_last
        |-> ##[1:5] (out_valid && out_status && out_last)) else $error("sw2 missing");
    AST_TAKE_BUSY: assert property (cmd_valid && cmd_ready |=> busy && !cmd_ready)
        else $error("header taken but block not busy");
    // only a last trailer byte may still wait while a new header can be taken
    AST_READY_IDLE: assert property (cmd_ready && out_valid |-> out_status && out_last)
        else $error("answer byte left over while ready for a header");
    AST_C4_NO_OK: assert property (
        out_valid && out_last && !t1_ff && case_ff == 2'h3
        && !fetch_ff |-> !(sw1_ff == 8'h90 && out_byte == 8'h00))
        else $error("case 4 ended with plain success");
    AST_PB_CASES: assert property (
        out_valid && out_status && !out_last && !t1_ff && !fetch_ff
        && !case_ff[0] |-> out_byte != atm_pkg::PB_FETCH && out_byte != atm_pkg::PB_RESEND)
        else $error("fetch code on case 1 or 3");
    AST_T1_DATA_SW: assert property (
        out_valid && out_status && !out_last && t1_ff && data_ff
        |-> out_byte[7:4] == atm_pkg::SW1_APP_HI || out_byte == atm_pkg::SW1_WARN_A
        || out_byte == atm_pkg::SW1_WARN_B) else $error("data sent with error status");

endmodule // atm_transport_mapper_checker

bind atm_transport_mapper atm_transport_mapper_checker atm_transport_mapper_checker_inst
(
    .clk_sys, .rst_b, .proto_t1, .cmd_valid, .cmd_ready, .cmd_case, .cmd_fetch,
    .out_valid, .out_byte, .out_status, .out_last, .out_ready, .busy
);

//--- testbench/atm_term_model.sv
// Purpose: terminal-side link sink taking answer bytes from the card
// Assumes: slow selects a one-in-four acceptance rate
// Notes:   accepted bytes are echoed one cycle later for the bench to judge
`timescale 1ns/1ps
module atm_term_model
(
    input  wire logic       clk_sys,
    input  wire logic       slow,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_byte,
    input  wire logic       out_status,
    input  wire logic       out_last,
    output logic            out_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_status,
    output logic            rx_last
);
    logic [1:0] ph_ff = 2'h0;

    // a slow terminal stalls three cycles in four, to exercise the hold rule
    assign out_ready = !slow || (ph_ff == 2'h3);

    // accepted bytes are echoed to the bench one cycle later, unaltered
    always_ff @(posedge clk_sys)
    begin
        ph_ff     <= ph_ff + 2'h1;
        rx_valid  <= out_valid && out_ready;
        rx_byte   <= out_byte;
        rx_status <= out_status;
        rx_last   <= out_last;
    end
endmodule // atm_term_model

//--- testbench/apdu_transport_mapper_bench.sv
// Purpose: self-checking bench for the card-side transport mapper
// Assumes: bench drives 1 ns after each rising edge
// Notes:   data bytes carry a running value so order and loss show up
`timescale 1ns/1ps
module apdu_transport_mapper_bench;
    logic       clk_sys, rst_b, proto_t1, cmd_valid, cmd_ready, cmd_fetch, busy, slow;
    logic       app_done, app_data_valid, app_data_ready;
    logic       out_valid, out_status, out_last, out_ready, rx_valid, rx_status, rx_last;
    logic [1:0] cmd_case;
    logic [7:0] cmd_le, app_data, out_byte, rx_byte;
    logic [8:0] app_avail;
    logic [15:0] app_sw;
    int         mismatches = 0;
    int         n_compared = 0;
    int         cycles = 0;

    atm_transport_mapper atm_transport_mapper_inst (.clk_sys, .rst_b, .proto_t1, .cmd_valid,
        .cmd_ready, .cmd_case, .cmd_fetch, .cmd_le, .app_done, .app_sw, .app_avail, .app_data,
        .app_data_valid, .app_data_ready, .out_valid, .out_byte, .out_status, .out_last,
        .out_ready, .busy);
    atm_term_model atm_term_model_inst (.clk_sys, .slow, .out_valid, .out_byte, .out_status,
        .out_last, .out_ready, .rx_valid, .rx_byte, .rx_status, .rx_last);

    // 50 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop;
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // a hang is cut well above the few hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            report_and_stop;
        end
    end

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask

    // the producer stalls on a full buffer, so this may outlive its header
    task automatic push(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++)
        begin
            app_data = base + i[7:0];
            app_data_valid = 1'b1;
            while (!app_data_ready)
                tick;
            tick;
        end
        app_data_valid = 1'b0;
    endtask

    // one header, optional application result, then collect and judge the answer
    task automatic run(input logic t1, input logic [1:0] cs, input logic f, input logic [7:0] le,
        input logic [15:0] sw, input int av, input logic [7:0] pb, input int nd,
        input logic [7:0] eb, input logic [15:0] esw, input logic give);
        int n;
        logic [7:0] sw1;
        n = 0;
        sw1 = 8'h00;
        proto_t1 = t1;
        cmd_case = cs;
        cmd_fetch = f;
        cmd_le = le;
        cmd_valid = 1'b1; // header goes alone; command data is not modelled
        while (!cmd_ready)
            tick;
        tick;
        cmd_valid = 1'b0;
        if (give)
        begin
            fork
                push(av, pb);
            join_none
            app_sw = sw;
            app_avail = av[8:0];
            app_done = 1'b1;
            tick;
            app_done = 1'b0;
        end
        for (int k = 0; k < 3000; k++)
        begin
            tick;
            if (rx_valid === 1'b1 && rx_status === 1'b0)
            begin
                chk_byte(rx_byte, eb + n[7:0]);
                n++;
            end
            else if (rx_valid === 1'b1 && rx_last === 1'b1)
                break;
            else if (rx_valid === 1'b1)
                sw1 = rx_byte;
        end
        chk_word(n[15:0], nd[15:0]);
        chk_word({sw1, rx_byte}, esw);
    endtask

    task automatic t_case2_exact;
        run(0, 2'h1, 0, 8'h04, 16'h9000, 4, 8'h10, 4, 8'h10, 16'h9000, 1);
    endtask

    task automatic t_case2_split;
        run(0, 2'h1, 0, 8'h02, 16'h9000, 5, 8'h20, 2, 8'h20, 16'h6103, 1);
        run(0, 2'h1, 1, 8'h03, 16'h9000, 0, 8'h00, 3, 8'h22, 16'h9000, 0);
    endtask

    task automatic t_case2_resend;
        slow = 1'b1;
        run(0, 2'h1, 0, 8'h08, 16'h9000, 3, 8'h30, 0, 8'h00, 16'h6C03, 1);
        run(0, 2'h1, 0, 8'h03, 16'h9000, 0, 8'h00, 3, 8'h30, 16'h9000, 0);
        run(0, 2'h1, 0, 8'h00, 16'h9000, 3, 8'h40, 0, 8'h00, 16'h6C03, 1);
        run(0, 2'h1, 0, 8'h03, 16'h9000, 0, 8'h00, 3, 8'h40, 16'h9000, 0);
        slow = 1'b0;
    endtask

    task automatic t_case4_fetch;
        run(0, 2'h3, 0, 8'h00, 16'h9000, 40, 8'h50, 0, 8'h00, 16'h6128, 1);
        slow = 1'b1;
        run(0, 2'h1, 1, 8'h28, 16'h9000, 0, 8'h00, 40, 8'h50, 16'h9000, 0);
        slow = 1'b0;
    endtask

    task automatic t_case4_status;
        run(0, 2'h3, 0, 8'h00, 16'h6283, 2, 8'h80, 0, 8'h00, 16'h6283, 1);
        run(0, 2'h1, 1, 8'h00, 16'h9000, 0, 8'h00, 0, 8'h00, 16'h6C02, 0);
        run(0, 2'h1, 1, 8'h02, 16'h9000, 0, 8'h00, 2, 8'h80, 16'h9000, 0);
        run(0, 2'h3, 0, 8'h00, 16'h6A82, 2, 8'h90, 0, 8'h00, 16'h6A82, 1);
        run(0, 2'h1, 1, 8'h00, 16'h9000, 0, 8'h00, 0, 8'h00, 16'h6F00, 0);
    endtask

    task automatic t_pb_misuse;
        run(0, 2'h0, 0, 8'h00, 16'h6110, 0, 8'h00, 0, 8'h00, 16'h6F00, 1);
        run(0, 2'h2, 0, 8'h00, 16'h6C05, 0, 8'h00, 0, 8'h00, 16'h6F00, 1);
    endtask

    task automatic t_t1_map;
        run(1, 2'h3, 0, 8'h00, 16'h6300, 3, 8'hA0, 3, 8'hA0, 16'h6300, 1);
        run(1, 2'h3, 0, 8'h00, 16'h6A80, 3, 8'hB0, 0, 8'h00, 16'h6A80, 1);
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        rst_b = 1'b0;
        slow = 1'b0;
        proto_t1 = 1'b0;
        cmd_valid = 1'b0;
        cmd_fetch = 1'b0;
        cmd_case = 2'h0;
        cmd_le = 8'h00;
        app_done = 1'b0;
        app_sw = 16'h0000;
        app_avail = 9'h000;
        app_data = 8'h00;
        app_data_valid = 1'b0;
        repeat (8) tick;
        rst_b = 1'b1;
        t_case2_exact;
        t_case2_split;
        t_case2_resend;
        t_case4_fetch;
        t_case4_status;
        t_pb_misuse;
        t_t1_map;
        report_and_stop;
    end
endmodule // apdu_transport_mapper_bench
